// [core/tc_params.sv]
// Offset and temperature compensation parameter store and selector
//
// Strobed register access was chosen for this implementation.
`default_nettype none
module tc_params (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [9:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Signal path inputs
  input  wire logic [15:0] sel_range,
  input  wire logic [15:0] temp_c,
  input  wire logic        temp_load,
  // Signal path outputs
  output logic signed [15:0] coarse_pct_x100,
  output logic signed [47:0] ofs_drift_ug,
  output logic signed [15:0] sens1_coeff,
  output logic signed [15:0] sens2_coeff,
  output logic        [1:0]  sens_src
);
  // ****************************************
  // Storage
  // ****************************************
  logic [4:0]  coarse;         // Coarse offset code
  logic [7:0]  ofs_drift;      // First-order offset drift
  logic [7:0]  sens1_cold;     // First-order cold
  logic [7:0]  sens1_hot;      // First-order hot
  logic [8:0]  sens2_cold;     // Second-order cold
  logic [8:0]  sens2_hot;      // Second-order hot
  logic        prog_tc;        // Any sensitivity coefficient written
  logic [15:0] def_range;      // Default range
  logic [15:0] factory_coeff;  // Factory sensitivity coefficient
  logic [15:0] temp_reg;       // Latched temperature
  logic signed [47:0] next_drift; // Scaled drift
  // ****************************************
  // Helpers
  // ****************************************
  // Sign extend an 8-bit code
  function automatic logic signed [15:0] sx8(input logic [7:0] v);
    sx8 = 16'($signed(v));
  endfunction
  // Sign extend a 9-bit code
  function automatic logic signed [15:0] sx9(input logic [8:0] v);
    sx9 = 16'($signed(v));
  endfunction
  // Write decode
  function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
    hit = (a == r);
  endfunction
  // ****************************************
  // Register writes
  // ****************************************
  // Coarse offset word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coarse <= tc_pkg::COARSE_RESET;
    end else if (wr && hit(addr, tc_pkg::ADDR_COARSE)) begin
      coarse <= wdata[tc_pkg::COARSE_LSB +: tc_pkg::COARSE_W];
    end
  end
  // First-order word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ofs_drift  <= tc_pkg::TC1_RESET;
      sens1_cold <= tc_pkg::TC1_RESET;
      sens1_hot  <= tc_pkg::TC1_RESET;
    end else if (wr && hit(addr, tc_pkg::ADDR_FIRST_ORDER)) begin
      ofs_drift  <= wdata[tc_pkg::OFS_DRIFT_LSB +: tc_pkg::TC1_W];
      sens1_cold <= wdata[tc_pkg::SENS1_COLD_LSB +: tc_pkg::TC1_W];
      sens1_hot  <= wdata[tc_pkg::SENS1_HOT_LSB +: tc_pkg::TC1_W];
    end
  end
  // Second-order word
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sens2_cold <= tc_pkg::TC2_RESET;
      sens2_hot  <= tc_pkg::TC2_RESET;
    end else if (wr && hit(addr, tc_pkg::ADDR_SECOND_ORDER)) begin
      sens2_cold <= wdata[tc_pkg::SENS2_COLD_LSB +: tc_pkg::TC2_W];
      sens2_hot  <= wdata[tc_pkg::SENS2_HOT_LSB +: tc_pkg::TC2_W];
    end
  end
  // Programmed flag: set by any write to the first- or second-order word, cleared by control bit 31
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_tc <= 1'b0;
    end else if (wr && hit(addr, tc_pkg::ADDR_CONTROL) && wdata[31]) begin
      prog_tc <= 1'b0;
    end else if (wr && (hit(addr, tc_pkg::ADDR_FIRST_ORDER) ||
                        hit(addr, tc_pkg::ADDR_SECOND_ORDER))) begin
      prog_tc <= 1'b1;
    end
  end
  // Control word: default range and factory coefficient
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      def_range     <= tc_pkg::RANGE_RESET;
      factory_coeff <= tc_pkg::FACTORY_TC_RESET;
    end else if (wr && hit(addr, tc_pkg::ADDR_CONTROL)) begin
      def_range     <= wdata[15:0];
      factory_coeff <= {1'b0, wdata[30:16]};
    end
  end
  // Temperature capture, from pin pulse or register write
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      temp_reg <= tc_pkg::TEMP_REF;
    end else if (wr && hit(addr, tc_pkg::ADDR_TEMP)) begin
      temp_reg <= wdata[15:0];
    end else if (temp_load) begin
      temp_reg <= temp_c;
    end
  end
  // ****************************************
  // Range scaling of offset drift
  // ****************************************
  tc_range_scale #(
    .CW (8)
  ) u_scale (
    .code        ($signed(ofs_drift)),
    .sel_range   (sel_range),
    .def_range   (def_range),
    .step_scaled (next_drift)
  );
  // ****************************************
  // Outputs
  // ****************************************
  // Coarse offset in hundredths of percent: code * 625
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coarse_pct_x100 <= 16'sh0000;
    end else begin
      // Product kept at 32 bits so code -16 does not wrap before the divide
      coarse_pct_x100 <= 16'(32'($signed(coarse)) *
                         32'sd10000 / 32'(tc_pkg::COARSE_PCT_DIV));
    end
  end
  // Scaled offset drift
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ofs_drift_ug <= 48'sh0;
    end else begin
      ofs_drift_ug <= next_drift;
    end
  end
  // Sensitivity coefficient choice by temperature side
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sens1_coeff <= 16'sh0000;
      sens2_coeff <= 16'sh0000;
      sens_src    <= tc_pkg::SRC_NONE;
    end else if (temp_reg == tc_pkg::TEMP_REF) begin
      sens1_coeff <= 16'sh0000;
      sens2_coeff <= 16'sh0000;
      sens_src    <= tc_pkg::SRC_NONE;
    end else if (!prog_tc) begin
      sens1_coeff <= $signed(factory_coeff);
      sens2_coeff <= 16'sh0000;
      sens_src    <= tc_pkg::SRC_FACTORY;
    end else if ($signed(temp_reg) > $signed(tc_pkg::TEMP_REF)) begin
      sens1_coeff <= sx8(sens1_hot);
      sens2_coeff <= sx9(sens2_hot);
      sens_src    <= tc_pkg::SRC_HOT;
    end else begin
      sens1_coeff <= sx8(sens1_cold);
      sens2_coeff <= sx9(sens2_cold);
      sens_src    <= tc_pkg::SRC_COLD;
    end
  end
  // Read data, one cycle after strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      case (addr)
        tc_pkg::ADDR_COARSE:       rdata <= {23'h0, coarse, 4'h0};
        tc_pkg::ADDR_FIRST_ORDER:  rdata <= {8'h0, sens1_hot, sens1_cold, ofs_drift};
        tc_pkg::ADDR_SECOND_ORDER: rdata <= {8'h0, sens2_hot, sens2_cold, 6'h00};
        tc_pkg::ADDR_CONTROL:      rdata <= {1'b0, factory_coeff[14:0], def_range};
        tc_pkg::ADDR_TEMP:         rdata <= {16'h0, temp_reg};
        tc_pkg::ADDR_RESULT0:      rdata <= {coarse_pct_x100, ofs_drift_ug[15:0]};
        tc_pkg::ADDR_RESULT1:      rdata <= {13'h0, prog_tc, sens_src,
                                              sens1_coeff[7:0], sens2_coeff[7:0]};
        default:                   rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule // tc_params
`default_nettype wire

// [core/tc_pkg.sv]
// Package with register map, field layouts and constants of the compensation parameter block
`default_nettype none
package tc_pkg;
  // ****************************************
  // Register addresses (word index = byte address / 4)
  // ****************************************
  localparam logic [7:0]  REG_IDX_SECOND_ORDER = 8'h08; // Second-order sensitivity word
  localparam logic [7:0]  REG_IDX_FIRST_ORDER  = 8'h09; // First-order coefficients word
  localparam logic [7:0]  REG_IDX_COARSE       = 8'h1C; // Coarse offset word
  localparam logic [7:0]  REG_IDX_CONTROL      = 8'h20; // Range and factory default
  localparam logic [7:0]  REG_IDX_TEMP         = 8'h21; // Temperature input
  localparam logic [7:0]  REG_IDX_RESULT0      = 8'h22; // Offset results
  localparam logic [7:0]  REG_IDX_RESULT1      = 8'h23; // Sensitivity results
  localparam logic [9:0]  ADDR_SECOND_ORDER    = {REG_IDX_SECOND_ORDER, 2'b00};
  localparam logic [9:0]  ADDR_FIRST_ORDER     = {REG_IDX_FIRST_ORDER, 2'b00};
  localparam logic [9:0]  ADDR_COARSE          = {REG_IDX_COARSE, 2'b00};
  localparam logic [9:0]  ADDR_CONTROL         = {REG_IDX_CONTROL, 2'b00};
  localparam logic [9:0]  ADDR_TEMP            = {REG_IDX_TEMP, 2'b00};
  localparam logic [9:0]  ADDR_RESULT0         = {REG_IDX_RESULT0, 2'b00};
  localparam logic [9:0]  ADDR_RESULT1         = {REG_IDX_RESULT1, 2'b00};
  // ****************************************
  // Field positions
  // ****************************************
  localparam int COARSE_LSB      = 4;  // Coarse offset bits 8:4
  localparam int COARSE_W        = 5;
  localparam int OFS_DRIFT_LSB   = 0;  // First-order offset bits 7:0
  localparam int SENS1_COLD_LSB  = 8;  // First-order cold bits 15:8
  localparam int SENS1_HOT_LSB   = 16; // First-order hot bits 23:16
  localparam int TC1_W           = 8;
  localparam int SENS2_COLD_LSB  = 6;  // Second-order cold bits 14:6
  localparam int SENS2_HOT_LSB   = 15; // Second-order hot bits 23:15
  localparam int TC2_W           = 9;
  // ****************************************
  // Values after reset and scales
  // ****************************************
  localparam logic [4:0]  COARSE_RESET      = 5'h00;
  localparam logic [7:0]  TC1_RESET         = 8'h00;
  localparam logic [8:0]  TC2_RESET         = 9'h000;
  localparam logic [15:0] RANGE_RESET       = 16'h01F4; // Default range half-span in gauss
  localparam logic [15:0] FACTORY_TC_RESET  = 16'h0000; // Factory sensitivity coefficient
  localparam logic [15:0] TEMP_REF          = 16'h0019; // 25 degC reference
  localparam int          COARSE_PCT_DIV    = 16;       // Code step = 100 % / 16 = 6.25 %
  localparam int          OFS_STEP_UG       = 7600;     // 0.0076 G per code in micro-gauss
  // ****************************************
  // Coefficient source selection
  // ****************************************
  typedef enum logic [1:0] {SRC_NONE, SRC_HOT, SRC_COLD, SRC_FACTORY} sens_src_t;
endpackage : tc_pkg
`default_nettype wire

// [core/tc_range_scale.sv]
// Signed coefficient times range ratio scaler
`default_nettype none
module tc_range_scale #(
  parameter int CW = 8
) (
  // Inputs
  input  wire logic signed [CW-1:0] code,
  input  wire logic        [15:0]   sel_range,
  input  wire logic        [15:0]   def_range,
  // Result in micro-gauss per degree
  output logic signed      [47:0]   step_scaled
);
  // Product of code, step and selected range
  logic signed [47:0] prod;
  always_comb begin
    prod = 48'(code) * 48'(tc_pkg::OFS_STEP_UG) * 48'($signed({1'b0, sel_range}));
    if (def_range == 16'h0000) begin
      step_scaled = prod;
    end else begin
      step_scaled = prod / 48'($signed({1'b0, def_range}));
    end
  end
endmodule // tc_range_scale
`default_nettype wire

// [tb/tc_params_properties.sv]
// Port checker of the compensation parameter block
`default_nettype none
module tc_params_properties (
  // Clock, reset and read port
  input wire logic               ref_clk,
  input wire logic               rst_n,
  input wire logic               rd,
  input wire logic        [31:0] rdata,
  // Signal path
  input wire logic        [15:0] sel_range,
  input wire logic        [15:0] temp_c,
  input wire logic               temp_load,
  input wire logic signed [15:0] coarse_pct_x100,
  input wire logic signed [47:0] ofs_drift_ug,
  input wire logic signed [15:0] sens1_coeff,
  input wire logic signed [15:0] sens2_coeff,
  input wire logic        [1:0]  sens_src
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_RDATA_IDLE:
    assert property (!$past(rd) |-> rdata == 32'h0) else $error("read data outside slot");
  AST_COARSE_STEP:
    assert property (coarse_pct_x100 % 625 == 0 && coarse_pct_x100 >= -10000 &&
      coarse_pct_x100 <= 9375) else $error("coarse offset off scale");
  AST_DRIFT_STEP:
    assert property ((sel_range == 16'h01F4) [*2] |-> ofs_drift_ug % 7600 == 0)
      else $error("drift not whole steps");
  AST_DRIFT_NO_RANGE:
    assert property ((sel_range == 16'h0000) [*2] |-> ofs_drift_ug == 0)
      else $error("drift without range");
  AST_SENS1_WIDTH:
    assert property (sens_src != 2'd3 |-> sens1_coeff >= -128 && sens1_coeff <= 127)
      else $error("first-order coefficient too wide");
  AST_HOT:
    assert property (temp_load && $signed(temp_c) > 16'sd25 |->
      ##[1:3] sens_src inside {2'd1, 2'd3}) else $error("hot side not chosen");
  AST_COLD:
    assert property (temp_load && $signed(temp_c) < 16'sd25 |->
      ##[1:3] sens_src inside {2'd2, 2'd3}) else $error("cold side not chosen");
  AST_REF:
    assert property (temp_load && temp_c == 16'h0019 |-> ##[1:3] sens_src == 2'd0)
      else $error("reference temperature not neutral");
  AST_NONE_ZERO:
    assert property (sens_src == 2'd0 |-> sens1_coeff == 0 && sens2_coeff == 0)
      else $error("correction at reference");
endmodule // tc_params_properties
bind tc_params tc_params_properties i_chk (.ref_clk, .rst_n, .rd, .rdata, .sel_range,
  .temp_c, .temp_load, .coarse_pct_x100, .ofs_drift_ug, .sens1_coeff, .sens2_coeff, .sens_src);
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench of the compensation parameter block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic               ref_clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               temp_load = 1'b0;
  logic        [9:0]  addr = 10'h000;
  logic        [31:0] wdata = 32'h0;
  logic        [15:0] sel_range = 16'h01F4;
  logic        [15:0] temp_c = 16'h0019;
  logic        [31:0] rdata;
  logic signed [15:0] coarse_pct_x100, sens1_coeff, sens2_coeff;
  logic signed [47:0] ofs_drift_ug;
  logic        [1:0]  sens_src;
  logic        [31:0] seed = 32'h788D9151;                 // Random source state
  logic        [4:0]  codes [4] = '{5'h00, 5'h10, 5'h0F, 5'h18}; // Coarse corners
  logic        [15:0] ranges [5] = '{16'h01F4, 16'h00FA, 16'h03E8, 16'h0000, 16'h0005};
  int                 mismatches = 0;
  int                 total_checks = 0;
  tc_params i_dut (.ref_clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .sel_range, .temp_c,
    .temp_load, .coarse_pct_x100, .ofs_drift_ug, .sens1_coeff, .sens2_coeff, .sens_src);
  // ****************************************
  // Helpers
  // ****************************************
  initial forever #10 ref_clk = ~ref_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Drift step scaled by selected over default range
  function automatic longint exp_drift(input logic [7:0] c, input logic [15:0] r);
    return longint'($signed(c)) * tc_pkg::OFS_STEP_UG * longint'(r) / 500;
  endfunction
  task automatic chk(input logic signed [47:0] seen, input logic signed [47:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic settle;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic load_temp(input logic [15:0] t);
    @(posedge ref_clk);
    temp_c    <= t;
    temp_load <= 1'b1;
    @(posedge ref_clk);
    temp_load <= 1'b0;
    settle;
  endtask
  task automatic stop_test;
    if (mismatches == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    stop_test;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk(sens_src, 2'd0);
    chk(coarse_pct_x100, 0);
    // Coarse offset corners then random codes
    for (int i = 0; i < 8; i++) begin
      logic [4:0] c;
      seed = lfsr(seed);
      c = (i < 4) ? codes[i] : seed[4:0];
      wr_reg(tc_pkg::ADDR_COARSE, 32'(c) << tc_pkg::COARSE_LSB);
      settle;
      chk(coarse_pct_x100, $signed(c) * (10000 / tc_pkg::COARSE_PCT_DIV));
      rd_chk(tc_pkg::ADDR_COARSE, 32'(c) << tc_pkg::COARSE_LSB);
    end
    // Nothing programmed yet: factory coefficient
    wr_reg(tc_pkg::ADDR_CONTROL, {1'b0, 15'h0033, tc_pkg::RANGE_RESET});
    load_temp(16'h0028);
    chk(sens_src, 2'd3);
    chk(sens1_coeff, 16'sh0033);
    // Programmed coefficients over ranges and temperatures
    for (int i = 0; i < 5; i++) begin
      logic [23:0] w1;
      logic [17:0] w2;
      seed = lfsr(seed);
      w1 = seed[23:0];
      seed = lfsr(seed);
      w2 = seed[17:0];
      if (i == 4) ranges[4] = 16'(5 * (seed[31:24] + 1));
      @(posedge ref_clk);
      sel_range <= ranges[i];
      wr_reg(tc_pkg::ADDR_FIRST_ORDER, {8'h00, w1});
      wr_reg(tc_pkg::ADDR_SECOND_ORDER, {8'h00, w2, 6'h00});
      load_temp(16'h0028);
      chk(ofs_drift_ug, exp_drift(w1[7:0], ranges[i]));
      chk(sens_src, 2'd1);
      chk(sens1_coeff, $signed(w1[23:16]));
      chk(sens2_coeff, $signed(w2[17:9]));
      rd_chk(tc_pkg::ADDR_FIRST_ORDER, {8'h00, w1});
      rd_chk(tc_pkg::ADDR_SECOND_ORDER, {8'h00, w2, 6'h00});
      load_temp(16'hFFF6);
      chk(sens_src, 2'd2);
      chk(sens1_coeff, $signed(w1[15:8]));
      chk(sens2_coeff, $signed(w2[8:0]));
      load_temp(16'h0019);
      chk(sens_src, 2'd0);
      rd_chk(tc_pkg::ADDR_TEMP, 32'h0000_0019);
    end
    // Programmed flag cleared: factory again
    load_temp(16'h0028);
    wr_reg(tc_pkg::ADDR_CONTROL, {1'b1, 15'h0033, tc_pkg::RANGE_RESET});
    settle;
    chk(sens_src, 2'd3);
    chk(sens1_coeff, 16'sh0033);
    rd_chk(tc_pkg::ADDR_RESULT1, 32'h0003_3300);
    rd_chk(10'h3FC, 32'h0);
    stop_test;
  end
endmodule // tb_top
`default_nettype wire
